// ---- rtl/vintc_pkg.sv ----
// Shared constants of the vectored interrupt controller
package vintc_pkg;
    localparam int VINTC_NSRC = 32;
    localparam int VINTC_NSLOT = 16;
    localparam int VINTC_AW = 32;
    localparam logic [31:0] VINTC_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] VINTC_FAST_RST = 32'h0000_0000;
    localparam logic [15:0] VINTC_SLOT_RST = 16'h0000;
    localparam logic [31:0] VINTC_ADDR_RST = 32'h0000_0000;
endpackage

// ---- rtl/vintc_vec_mem.sv ----
// Handler address store, one word per vectored slot
`timescale 1ns/1ps
`default_nettype none
module vintc_vec_mem
    import vintc_pkg::*;
#(
    parameter int DEPTH = VINTC_NSLOT,
    parameter int WIDTH = VINTC_AW
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    typedef struct packed {
        logic [WIDTH-1:0] rdata;
    } vintc_mem_s;

    logic [WIDTH-1:0] mem_r [DEPTH];
    vintc_mem_s st_r;
    vintc_mem_s st_nxt;

    // ****************************************
    // Storage and registered read
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = mem_r[raddr_i];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
endmodule
`default_nettype wire

// ---- rtl/vintc_top.sv ----
// Vectored interrupt controller core
// Functional notes
// [RQ1] Fast requests rank highest and all merge into one fast output.
// [RQ2] A status word shows which fast sources are requesting now.
// [RQ3] Sixteen slots take any source, slot 0 highest, slot 15 lowest.
// [RQ4] Vectored requests rank below fast and above non-vectored ones.
// [RQ5] All vectored and non-vectored requests merge into the normal output.
// [RQ6] A vector read gives the top slot handler, else the default handler.
// [RQ7] A status word shows which normal-class requests are active.
// [RQ8] Each peripheral drives exactly one request line, maybe many flags.
// [RQ9] After reset no source is enabled, fast or slotted; outputs stay low. A vector read still raises VECT_VALID_O and returns DEF_ADDR_I.
`timescale 1ns/1ps
`default_nettype none
module vintc_top
    import vintc_pkg::*;
#(
    parameter int NSRC = VINTC_NSRC,
    parameter int NSLOT = VINTC_NSLOT,
    parameter int AW = VINTC_AW
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [NSRC-1:0] REQ_I,
    input wire logic MASK_WE_I,
    input wire logic [NSRC-1:0] MASK_I,
    input wire logic FAST_WE_I,
    input wire logic [NSRC-1:0] FAST_SEL_I,
    input wire logic SLOT_WE_I,
    input wire logic [$clog2(NSLOT)-1:0] SLOT_IDX_I,
    input wire logic [$clog2(NSRC)-1:0] SLOT_SRC_I,
    input wire logic SLOT_ON_I,
    input wire logic [AW-1:0] SLOT_VEC_I,
    input wire logic [AW-1:0] DEF_ADDR_I,
    input wire logic VREAD_I,
    output logic [AW-1:0] VECT_ADDR_O,
    output logic VECT_VALID_O,
    output logic VECT_HIT_O,
    output logic FAST_INTERRUPT_REQUEST_O,
    output logic IRQ_O,
    output logic [NSRC-1:0] FAST_STAT_O,
    output logic [NSRC-1:0] NORM_STAT_O
);
    localparam int SW = $clog2(NSLOT);
    localparam int IW = $clog2(NSRC);

    typedef struct packed {
        logic [NSRC-1:0] mask;
        logic [NSRC-1:0] fast;
        logic [NSLOT-1:0][IW-1:0] slot_src;
        logic [NSLOT-1:0] slot_on;
        logic [NSRC-1:0] fstat;
        logic [NSRC-1:0] nstat;
        logic fint;
        logic irq;
        logic rd;
        logic hit;
        logic [SW-1:0] win;
        logic [NSLOT-1:0] pend;
        logic [AW-1:0] vec;
        logic valid;
        logic vhit;
    } vintc_state_s;

    vintc_state_s st_r;
    vintc_state_s st_nxt;
    logic [NSRC-1:0] fact;
    logic [NSRC-1:0] nact;
    logic [NSLOT-1:0] pend;
    logic [SW-1:0] win;
    logic hit;
    logic [AW-1:0] mem_q;

    // ****************************************
    // Handler address store
    // ****************************************
    vintc_vec_mem #(
        .DEPTH(NSLOT),
        .WIDTH(AW)
    ) u_vec_mem (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .we_i(SLOT_WE_I),
        .waddr_i(SLOT_IDX_I),
        .wdata_i(SLOT_VEC_I),
        .raddr_i(win),
        .rdata_o(mem_q)
    );

    // ****************************************
    // Classing, priority and vector read
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        fact = REQ_I & st_r.mask & st_r.fast; // RQ1
        nact = REQ_I & st_r.mask & ~st_r.fast; // RQ4
        pend = '0;
        win = '0;
        hit = 1'b0;
        for (int i = 0; i < NSLOT; i++) begin
            pend[i] = st_r.slot_on[i] & nact[st_r.slot_src[i]]; // RQ3
        end
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win = SW'(i); // RQ3
                hit = 1'b1;
            end
        end
        if (MASK_WE_I) begin
            st_nxt.mask = MASK_I;
        end
        if (FAST_WE_I) begin
            st_nxt.fast = FAST_SEL_I;
        end
        if (SLOT_WE_I) begin
            st_nxt.slot_src[SLOT_IDX_I] = SLOT_SRC_I;
            st_nxt.slot_on[SLOT_IDX_I] = SLOT_ON_I;
        end
        st_nxt.fstat = fact; // RQ2
        st_nxt.nstat = nact; // RQ7
        st_nxt.fint = |fact; // RQ1
        st_nxt.irq = |nact; // RQ5
        st_nxt.rd = VREAD_I;
        if (VREAD_I) begin
            st_nxt.hit = hit;
            st_nxt.win = win;
            st_nxt.pend = pend;
        end
        st_nxt.valid = st_r.rd;
        if (st_r.rd) begin
            st_nxt.vec = st_r.hit ? mem_q : DEF_ADDR_I; // RQ6
            st_nxt.vhit = st_r.hit;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r <= '0;
            st_r.mask <= VINTC_MASK_RST[NSRC-1:0]; // RQ9
            st_r.fast <= VINTC_FAST_RST[NSRC-1:0]; // RQ9
            st_r.slot_on <= VINTC_SLOT_RST[NSLOT-1:0]; // RQ9
            st_r.vec <= VINTC_ADDR_RST[AW-1:0];
        end else begin
            st_r <= st_nxt;
        end
    end

    assign VECT_ADDR_O = st_r.vec;
    assign VECT_VALID_O = st_r.valid;
    assign VECT_HIT_O = st_r.vhit;
    assign FAST_INTERRUPT_REQUEST_O = st_r.fint;
    assign IRQ_O = st_r.irq;
    assign FAST_STAT_O = st_r.fstat;
    assign NORM_STAT_O = st_r.nstat;

    // ****************************************
    // Checks, interrupt outputs
    // ****************************************
    a_fast_merge: assert property ( // RQ1
        @(posedge CLK_I) disable iff (!ARST_N_I)
        1'b1 |=> FAST_INTERRUPT_REQUEST_O ==
            $past(|(REQ_I & st_r.mask & st_r.fast)))
        else $error("fast output does not follow fast requests");
    a_fast_word: assert property ( // RQ2
        @(posedge CLK_I) disable iff (!ARST_N_I)
        1'b1 |=> FAST_STAT_O == $past(REQ_I & st_r.mask & st_r.fast))
        else $error("fast status word wrong");
    a_fast_only_req: assert property ( // RQ2
        @(posedge CLK_I) disable iff (!ARST_N_I)
        1'b1 |=> (FAST_STAT_O & ~$past(REQ_I)) == '0)
        else $error("fast status bit set without request");
    a_class_rank: assert property ( // RQ4
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (FAST_STAT_O & NORM_STAT_O) == '0)
        else $error("source counted in both classes");
    a_slot_not_fast: assert property ( // RQ4
        @(posedge CLK_I) disable iff (!ARST_N_I)
        hit |-> !st_r.fast[st_r.slot_src[win]])
        else $error("fast source won a vectored slot");
    a_norm_merge: assert property ( // RQ5
        @(posedge CLK_I) disable iff (!ARST_N_I)
        IRQ_O == (|NORM_STAT_O))
        else $error("normal output disagrees with normal status");
    a_norm_word: assert property ( // RQ7
        @(posedge CLK_I) disable iff (!ARST_N_I)
        1'b1 |=> NORM_STAT_O == $past(REQ_I & st_r.mask & ~st_r.fast))
        else $error("normal status word wrong");
    a_reset_quiet: assert property ( // RQ9
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (st_r.mask == '0) |=> !FAST_INTERRUPT_REQUEST_O && !IRQ_O)
        else $error("output active with every source disabled");
    a_reset_clear: assert property ( // RQ9
        @(posedge CLK_I) disable iff (!ARST_N_I)
        $rose(ARST_N_I) |-> st_r.mask == '0 && st_r.fast == '0 &&
            st_r.slot_on == '0)
        else $error("configuration not cleared by reset");

    // ****************************************
    // Checks, vector read
    // ****************************************
    a_slot_prio: assert property ( // RQ3
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (st_r.rd && st_r.hit) |-> (st_r.pend[st_r.win] &&
        ((st_r.pend & ((NSLOT'(1) << st_r.win) - NSLOT'(1))) == '0)))
        else $error("winning slot is not the highest pending");
    a_hit_any_pend: assert property ( // RQ3
        @(posedge CLK_I) disable iff (!ARST_N_I)
        VREAD_I |=> st_r.hit == (|st_r.pend))
        else $error("slot hit disagrees with pending slots");
    a_vec_pick: assert property ( // RQ6
        @(posedge CLK_I) disable iff (!ARST_N_I)
        VREAD_I ##1 !st_r.hit |=> VECT_VALID_O && !VECT_HIT_O &&
        VECT_ADDR_O == $past(DEF_ADDR_I))
        else $error("default handler not returned");
    a_vec_slot: assert property ( // RQ6
        @(posedge CLK_I) disable iff (!ARST_N_I)
        VREAD_I ##1 st_r.hit |=> VECT_VALID_O && VECT_HIT_O &&
        VECT_ADDR_O == $past(mem_q))
        else $error("slot handler not returned");
    a_vec_timing: assert property ( // RQ6
        @(posedge CLK_I) disable iff (!ARST_N_I)
        VREAD_I |-> ##2 VECT_VALID_O)
        else $error("vector answer not two cycles after read");
    a_vec_quiet: assert property ( // RQ6
        @(posedge CLK_I) disable iff (!ARST_N_I)
        !VREAD_I |-> ##2 !VECT_VALID_O)
        else $error("vector answer without a read");
    a_vec_hold: assert property ( // RQ6
        @(posedge CLK_I) disable iff (!ARST_N_I)
        !st_r.rd |=> $stable(VECT_ADDR_O) && $stable(VECT_HIT_O))
        else $error("vector answer changed without a read");
endmodule
`default_nettype wire

// ---- sim/vintc_periph_model.sv ----
// Peripheral side model: each peripheral folds its flags into one line
`timescale 1ns/1ps
`default_nettype none
module vintc_periph_model
    import vintc_pkg::*;
#(
    parameter int N = VINTC_NSRC
) (
    input wire logic [3*N-1:0] flags_i,
    output logic [N-1:0] req_o
);
    // ****************
    // Request merge
    // ****************
    always_comb begin
        req_o = flags_i[0+:N] | flags_i[N+:N] | flags_i[2*N+:N];
    end
endmodule
`default_nettype wire

// ---- sim/vintc_top_tb_top.sv ----
// Random self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vintc_top_tb_top
    import vintc_pkg::*;
;
    logic CLK_I = 0, ARST_N_I, MASK_WE_I, FAST_WE_I, SLOT_WE_I, SLOT_ON_I;
    logic VREAD_I, VECT_VALID_O, VECT_HIT_O, FAST_INTERRUPT_REQUEST_O, IRQ_O;
    logic [31:0] REQ_I, MASK_I, FAST_SEL_I, SLOT_VEC_I, DEF_ADDR_I;
    logic [31:0] VECT_ADDR_O, FAST_STAT_O, NORM_STAT_O, rq, m_mask = 0;
    logic [31:0] m_fast = 0, efs = 0, ens = 0, p1a = 0, p2a = 0, seed = 43135;
    logic [31:0] m_vec [16];
    logic [4:0] m_src [16];
    logic [3:0] SLOT_IDX_I;
    logic [4:0] SLOT_SRC_I;
    logic [15:0] m_on = 0;
    logic [95:0] flags;
    logic p1v = 0, p1h = 0, p2v = 0, p2h = 0;
    int num_errors = 0, comparisons = 0, cycles = 0;
    always #12.5 CLK_I = ~CLK_I;
    vintc_periph_model vintc_periph_model_inst (.flags_i(flags), .req_o(REQ_I));
    vintc_top vintc_top_inst (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
        .REQ_I(REQ_I), .MASK_WE_I(MASK_WE_I), .MASK_I(MASK_I),
        .FAST_WE_I(FAST_WE_I), .FAST_SEL_I(FAST_SEL_I), .SLOT_WE_I(SLOT_WE_I),
        .SLOT_IDX_I(SLOT_IDX_I), .SLOT_SRC_I(SLOT_SRC_I), .SLOT_ON_I(SLOT_ON_I),
        .SLOT_VEC_I(SLOT_VEC_I), .DEF_ADDR_I(DEF_ADDR_I), .VREAD_I(VREAD_I),
        .VECT_ADDR_O(VECT_ADDR_O), .VECT_VALID_O(VECT_VALID_O),
        .VECT_HIT_O(VECT_HIT_O), .IRQ_O(IRQ_O),
        .FAST_INTERRUPT_REQUEST_O(FAST_INTERRUPT_REQUEST_O),
        .FAST_STAT_O(FAST_STAT_O), .NORM_STAT_O(NORM_STAT_O));
    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************
    // Expected behaviour
    // ****************
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            {m_mask, m_fast, m_on, efs, ens, p1v, p1h, p2v} = '0;
        end else begin
            rq = flags[31:0] | flags[63:32] | flags[95:64];
            efs = rq & m_mask & m_fast;
            ens = rq & m_mask & ~m_fast;
            p2v = p1v;
            p2h = p1h;
            p2a = p1h ? p1a : DEF_ADDR_I;
            p1v = VREAD_I;
            p1h = 0;
            for (int s = 15; s >= 0; s--) begin
                if (m_on[s] && ens[m_src[s]]) begin
                    p1h = 1;
                    p1a = m_vec[s];
                end
            end
            if (MASK_WE_I) m_mask = MASK_I;
            if (FAST_WE_I) m_fast = FAST_SEL_I;
            if (SLOT_WE_I) begin
                m_on[SLOT_IDX_I] = SLOT_ON_I;
                m_src[SLOT_IDX_I] = SLOT_SRC_I;
                m_vec[SLOT_IDX_I] = SLOT_VEC_I;
            end
        end
    end
    always @(negedge CLK_I) begin
        chk(32'(FAST_INTERRUPT_REQUEST_O), 32'(|efs));
        chk(FAST_STAT_O, efs);
        chk(32'(IRQ_O), 32'(|ens));
        chk(NORM_STAT_O, ens);
        chk(32'(VECT_VALID_O), 32'(p2v));
        if (p2v) begin
            chk(VECT_ADDR_O, p2a);
            chk(32'(VECT_HIT_O), 32'(p2h));
        end
    end
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ****************
    // Stimulus
    // ****************
    initial begin
        ARST_N_I = 0;
        {MASK_WE_I, FAST_WE_I, SLOT_WE_I, SLOT_ON_I, VREAD_I} = '0;
        {MASK_I, FAST_SEL_I, SLOT_VEC_I, DEF_ADDR_I, SLOT_IDX_I} = '0;
        SLOT_SRC_I = '0;
        flags = '0;
        repeat (2) @(posedge CLK_I);
        ARST_N_I <= 1;
        for (int i = 0; i < 16; i++) begin
            @(posedge CLK_I);
            {SLOT_WE_I, SLOT_ON_I, MASK_WE_I, MASK_I} <= {3'h7, 32'hFFFF_FFFF};
            {SLOT_IDX_I, SLOT_SRC_I, SLOT_VEC_I} <= {i[3:0], i[4:0], rnd()};
            flags <= {64'h0, 32'h0001_8000};
        end
        for (int i = 0; i < 3000; i++) begin
            @(posedge CLK_I);
            flags <= {rnd() & rnd(), rnd() & rnd(), rnd() & rnd()};
            {MASK_WE_I, FAST_WE_I, SLOT_WE_I} <= 3'(rnd() & rnd() & rnd());
            MASK_I <= rnd() | rnd();
            FAST_SEL_I <= rnd() & rnd() & rnd();
            {SLOT_IDX_I, SLOT_SRC_I, SLOT_ON_I, VREAD_I} <= 11'(rnd());
            SLOT_VEC_I <= rnd();
            DEF_ADDR_I <= rnd();
        end
        // Mid-run reset, then requests with no configuration
        @(posedge CLK_I);
        {MASK_WE_I, FAST_WE_I, SLOT_WE_I, VREAD_I} <= '0;
        @(posedge CLK_I);
        ARST_N_I <= 0;
        repeat (2) @(posedge CLK_I);
        ARST_N_I <= 1;
        for (int i = 0; i < 300; i++) begin
            @(posedge CLK_I);
            flags <= {rnd(), rnd(), rnd()};
            VREAD_I <= 1'(rnd());
            DEF_ADDR_I <= rnd();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
